// *** rgt_defs.svh ***
// Register offsets, field positions and reset values of the general timers.
`ifndef RGT_DEFS_SVH
`define RGT_DEFS_SVH

// ****************************************************************
// Register indices; the byte address is four times the index.
// ****************************************************************
`define RGT_IDX_SHARED_CTL 6'h0e
`define RGT_IDX_T0_CTL 6'h0f
`define RGT_IDX_T0_RLD_HI 6'h10
`define RGT_IDX_T0_RLD_LO 6'h11
`define RGT_IDX_T0_CNT_HI 6'h12
`define RGT_IDX_T0_CNT_LO 6'h13
`define RGT_IDX_T1_CTL 6'h14
`define RGT_IDX_T1_RLD_HI 6'h15
`define RGT_IDX_T1_RLD_LO 6'h16
`define RGT_IDX_T1_CNT_HI 6'h17
`define RGT_IDX_T1_CNT_LO 6'h18
`define RGT_IDX_T2_CTL 6'h19
`define RGT_IDX_T2_RLD_HI 6'h1a
`define RGT_IDX_T2_RLD_LO 6'h1b
`define RGT_IDX_T2_CNT_HI 6'h1c
`define RGT_IDX_T2_CNT_LO 6'h1d
`define RGT_IDX_FLAGS 6'h20
`define RGT_IDX_STRIDE 6'h05

// ****************************************************************
// Field positions and masks.
// ****************************************************************
`define RGT_RUN_LSB 4
`define RGT_CTL_STOP_RX 7
`define RGT_CTL_AUTO 3
`define RGT_CTL_MASK 8'hbb

// ****************************************************************
// Reset values.
// ****************************************************************
`define RGT_CTL_RESET 8'h00
`define RGT_RLD_RESET 16'h0000
`define RGT_CNT_RESET 16'h0000

`endif

// *** rgt_pkg.sv ***
// Types shared by the general timer block.
package rgt_pkg;

	typedef enum logic [1:0] {
		RGT_START_NONE = 2'h0,
		RGT_START_TX_END = 2'h1,
		RGT_START_TRIM = 2'h2,
		RGT_START_TRIM_UF = 2'h3
	} rgt_start_mode_t;

	typedef enum logic [1:0] {
		RGT_CLK_CARRIER = 2'h0,
		RGT_CLK_DIVIDED = 2'h1,
		RGT_CLK_CASCADE_A = 2'h2,
		RGT_CLK_CASCADE_B = 2'h3
	} rgt_clock_sel_t;

	typedef struct packed {
		logic stop_on_receive;
		logic rsvd6;
		rgt_start_mode_t start_mode;
		logic auto_reload;
		logic rsvd2;
		rgt_clock_sel_t clock_select;
	} rgt_ctl_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} rgt_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} rgt_apb_rsp_t;

endpackage

// *** rgt_timers.sv ***
// Three cascadable 16-bit down-counting general timers with an APB register slave.
//
// Operation
// R1 - timer0 run bit changes only with mask
// R2 - stop-on-receive halts timer after four bits
// R3 - stop-on-receive ignored in trimming modes
// R4 - start mode: none, tx end, trimming
// R5 - auto reload at zero, else stop
// R6 - underflow sets the timer's flag
// R7 - timer0 clock: carrier, divided, t2, t1
// R8 - timer1 clock: carrier, divided, t0, t2
// R9 - timer2 clock: carrier, divided, t0, t1
// R10 - start event loads the reload word
// R11 - reload writes wait for next start
// R12 - host avoids counter reads during reception
// R13 - low nibble masks running bit writes
// R14 - running bit shows and sets state
// R15 - each selected tick decrements by one
// R16 - counter registers are read only
//
// Design decision made here: the APB register port.
`include "rgt_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module rgt_timers (
	input wire logic sys_clk, // 25 MHz system clock
	input wire logic rst_n, // asynchronous reset, active low
	input wire logic clk_en, // freezes all state while low
	input wire rgt_pkg::rgt_apb_req_t apb_req, // APB request
	output rgt_pkg::rgt_apb_rsp_t apb_rsp, // APB answer
	input wire logic carrier_clk_pin, // 13.56 MHz carrier clock
	input wire logic divided_clk_pin, // 211.875 kHz divided clock
	input wire logic low_freq_oscillator, // oscillator being trimmed
	input wire logic tx_end, // end of transmission pulse
	input wire logic rx_first_nibble, // first four bits received pulse
	output logic [2:0] timer_running, // running state per timer
	output logic [2:0] timer_underflow_flag, // sticky underflow flags
	output logic [2:0] timer_underflow // underflow pulse per timer
);
	import rgt_pkg::*;

	// ****************************************************************
	// Pin synchronisers and tick edges.
	// ****************************************************************
	logic [2:0] pin_meta_q;
	logic [2:0] pin_sync_q;
	logic [2:0] pin_prev_q;
	wire logic [2:0] pin_async = {low_freq_oscillator, divided_clk_pin, carrier_clk_pin};
	wire logic [2:0] pin_rise = pin_sync_q & ~pin_prev_q;
	wire logic carrier_tick = pin_rise[0];
	wire logic divided_tick = pin_rise[1];
	wire logic lfo_edge = pin_rise[2];

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_q <= 3'h0;
			pin_sync_q <= 3'h0;
			pin_prev_q <= 3'h0;
		end else if (clk_en) begin
			pin_meta_q <= pin_async;
			pin_sync_q <= pin_meta_q;
			pin_prev_q <= pin_sync_q;
		end
	end

	// ****************************************************************
	// APB decode.
	// ****************************************************************
	wire logic [5:0] reg_idx = apb_req.paddr[7:2];
	wire logic [7:0] wbyte = apb_req.pwdata[7:0];
	wire logic setup_ph = apb_req.psel & ~apb_req.penable;
	wire logic wr_access = apb_req.psel & apb_req.penable & apb_req.pwrite & clk_en;
	wire logic wr_shared = wr_access & (reg_idx == `RGT_IDX_SHARED_CTL);
	wire logic wr_flags = wr_access & (reg_idx == `RGT_IDX_FLAGS);

	// Register index of a per-timer register: base plus five per timer.
	function automatic logic [5:0] timer_idx(input logic [5:0] base, input int unsigned t);
		timer_idx = base + 6'(t) * `RGT_IDX_STRIDE;
	endfunction

	// Picks the tick for a timer from its clock select and the cascade sources.
	function automatic logic pick_tick(input rgt_clock_sel_t sel, input logic car,
			input logic dvd, input logic casc_a, input logic casc_b);
		unique case (sel)
			RGT_CLK_CARRIER: pick_tick = car;
			RGT_CLK_DIVIDED: pick_tick = dvd;
			RGT_CLK_CASCADE_A: pick_tick = casc_a;
			RGT_CLK_CASCADE_B: pick_tick = casc_b;
		endcase
	endfunction

	// ****************************************************************
	// Per-timer state.
	// ****************************************************************
	rgt_ctl_t ctl_q [3];
	logic [15:0] reload_q [3];
	logic [15:0] cnt_q [3];
	logic [15:0] cnt_d [3];
	logic [2:0] run_q;
	logic [2:0] run_d;
	logic [2:0] flag_q;
	logic [2:0] uf_q;
	logic [2:0] uf;
	logic [2:0] start_ev;
	logic [2:0] stop_ev;
	logic [2:0] rx_stop;
	logic [2:0] tick;
	logic [2:0] trim;

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_tmr
			localparam int unsigned SRC_A = (gi == 0) ? 2 : 0;
			localparam int unsigned SRC_B = (gi == 1) ? 2 : 1;
			wire logic wr_ctl = wr_access & (reg_idx == timer_idx(`RGT_IDX_T0_CTL, gi));
			wire logic wr_hi = wr_access & (reg_idx == timer_idx(`RGT_IDX_T0_RLD_HI, gi));
			wire logic wr_lo = wr_access & (reg_idx == timer_idx(`RGT_IDX_T0_RLD_LO, gi));
			wire logic mask_run = wr_shared & wbyte[gi]; // [R1] [R13]
			wire logic run_val = wbyte[`RGT_RUN_LSB + gi];
			wire logic tx_start = (ctl_q[gi].start_mode == RGT_START_TX_END) & tx_end; // [R4]
			wire logic lfo_hit = trim[gi] & lfo_edge;
			wire logic at_zero = (cnt_q[gi] == 16'h0000);
			wire logic no_uf = (ctl_q[gi].start_mode == RGT_START_TRIM);

			// Trimming modes start on one oscillator edge and stop on the next.
			assign trim[gi] = ctl_q[gi].start_mode[1]; // [R4]
			assign rx_stop[gi] = ctl_q[gi].stop_on_receive & ~trim[gi] & rx_first_nibble; // [R2] [R3]
			assign start_ev[gi] = (mask_run & run_val) | tx_start | (lfo_hit & ~run_q[gi]); // [R14]
			assign stop_ev[gi] = (mask_run & ~run_val) | (run_q[gi] & (rx_stop[gi] | lfo_hit));
			// Cascade ticks come from registered underflows, so no timer loop is combinational.
			assign tick[gi] = run_q[gi] & pick_tick(ctl_q[gi].clock_select, carrier_tick,
				divided_tick, uf_q[SRC_A], uf_q[SRC_B]); // [R7] [R8] [R9] [R15]
			assign uf[gi] = tick[gi] & at_zero & ~no_uf & ~start_ev[gi] & ~stop_ev[gi];

			always_comb begin
				cnt_d[gi] = cnt_q[gi];
				run_d[gi] = run_q[gi];
				if (stop_ev[gi]) begin
					run_d[gi] = 1'b0;
				end else if (start_ev[gi]) begin
					cnt_d[gi] = reload_q[gi]; // [R10]
					run_d[gi] = 1'b1;
				end else if (tick[gi] & ~at_zero) begin
					cnt_d[gi] = cnt_q[gi] - 16'h0001; // [R15]
				end else if (uf[gi]) begin
					if (ctl_q[gi].auto_reload) begin
						cnt_d[gi] = reload_q[gi]; // [R5]
					end else begin
						run_d[gi] = 1'b0; // [R5]
					end
				end
			end

			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					ctl_q[gi] <= `RGT_CTL_RESET;
					reload_q[gi] <= `RGT_RLD_RESET;
					cnt_q[gi] <= `RGT_CNT_RESET;
				end else if (clk_en) begin
					if (wr_ctl) begin
						ctl_q[gi] <= wbyte & `RGT_CTL_MASK;
					end
					// Reload bytes only reach the counter at a start event or at an underflow with auto reload set.
					if (wr_hi) begin
						reload_q[gi][15:8] <= wbyte; // [R11]
					end
					if (wr_lo) begin
						reload_q[gi][7:0] <= wbyte; // [R11]
					end
					cnt_q[gi] <= cnt_d[gi]; // [R16]
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Running bits, underflow pulses and sticky flags.
	// ****************************************************************
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			run_q <= 3'h0;
			uf_q <= 3'h0;
			flag_q <= 3'h0;
		end else if (clk_en) begin
			run_q <= run_d; // [R14]
			uf_q <= uf;
			// A new underflow wins over a write-one-to-clear in the same cycle.
			flag_q <= (flag_q & ~(wr_flags ? wbyte[2:0] : 3'h0)) | uf; // [R6]
		end
	end

	assign timer_running = run_q;
	assign timer_underflow_flag = flag_q;
	assign timer_underflow = uf_q;

	// ****************************************************************
	// Read mux, registered in the setup phase.
	// ****************************************************************
	logic [7:0] rd_byte;
	logic rd_hit;

	always_comb begin
		rd_byte = 8'h00;
		rd_hit = 1'b1;
		unique case (reg_idx)
			`RGT_IDX_SHARED_CTL: rd_byte = {1'b0, run_q, 4'h0};
			`RGT_IDX_T0_CTL: rd_byte = ctl_q[0];
			`RGT_IDX_T0_RLD_HI: rd_byte = reload_q[0][15:8];
			`RGT_IDX_T0_RLD_LO: rd_byte = reload_q[0][7:0];
			`RGT_IDX_T0_CNT_HI: rd_byte = cnt_q[0][15:8];
			`RGT_IDX_T0_CNT_LO: rd_byte = cnt_q[0][7:0];
			`RGT_IDX_T1_CTL: rd_byte = ctl_q[1];
			`RGT_IDX_T1_RLD_HI: rd_byte = reload_q[1][15:8];
			`RGT_IDX_T1_RLD_LO: rd_byte = reload_q[1][7:0];
			`RGT_IDX_T1_CNT_HI: rd_byte = cnt_q[1][15:8];
			`RGT_IDX_T1_CNT_LO: rd_byte = cnt_q[1][7:0];
			`RGT_IDX_T2_CTL: rd_byte = ctl_q[2];
			`RGT_IDX_T2_RLD_HI: rd_byte = reload_q[2][15:8];
			`RGT_IDX_T2_RLD_LO: rd_byte = reload_q[2][7:0];
			`RGT_IDX_T2_CNT_HI: rd_byte = cnt_q[2][15:8];
			`RGT_IDX_T2_CNT_LO: rd_byte = cnt_q[2][7:0];
			`RGT_IDX_FLAGS: rd_byte = {5'h00, flag_q};
			default: rd_hit = 1'b0;
		endcase
	end

	logic [7:0] prdata_q;
	logic pslverr_q;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_q <= 8'h00;
			pslverr_q <= 1'b0;
		end else if (clk_en & setup_ph) begin
			prdata_q <= rd_byte;
			pslverr_q <= ~rd_hit;
		end
	end

	assign apb_rsp.pready = apb_req.psel & apb_req.penable & clk_en;
	assign apb_rsp.pslverr = pslverr_q;
	assign apb_rsp.prdata = {24'h000000, prdata_q};

	// ****************************************************************
	// Checks.
	// ****************************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence s_t0_quiet;
		clk_en && !start_ev[0] && !stop_ev[0] && !uf[0];
	endsequence

	sequence s_t1_cascade_tick;
		clk_en && run_q[1] && ctl_q[1].clock_select == RGT_CLK_CASCADE_A && uf_q[0]
			&& cnt_q[1] != 16'h0000 && !start_ev[1] && !stop_ev[1];
	endsequence

	chk_mask_guard: assert property ( // [R1]
		wr_shared && !wbyte[0] ##0 s_t0_quiet |=> run_q[0] == $past(run_q[0]))
		else $error("timer0 running bit changed without its mask bit");

	chk_rx_halt: assert property ( // [R2]
		clk_en && run_q[0] && ctl_q[0].stop_on_receive && !trim[0] && rx_first_nibble
			|=> !run_q[0])
		else $error("timer0 kept running after the first received nibble");

	chk_trim_ignore: assert property ( // [R3]
		trim[1] |-> !rx_stop[1])
		else $error("timer1 stop-on-receive acted in a trimming mode");

	chk_tx_start: assert property ( // [R4] [R10]
		clk_en && ctl_q[2].start_mode == RGT_START_TX_END && tx_end && !stop_ev[2]
			|=> run_q[2] && cnt_q[2] == $past(reload_q[2]))
		else $error("timer2 did not load and start at end of transmission");

	chk_reload_wrap: assert property ( // [R5]
		clk_en && uf[0] && ctl_q[0].auto_reload
			|=> run_q[0] && cnt_q[0] == $past(reload_q[0]) ##1 timer_underflow[0] == 1'b0)
		else $error("timer0 did not reload after underflow");

	chk_one_shot_stop: assert property ( // [R5]
		clk_en && uf[1] && !ctl_q[1].auto_reload |=> !run_q[1] && cnt_q[1] == 16'h0000)
		else $error("timer1 kept running after a one-shot underflow");

	chk_flag_set: assert property ( // [R6]
		clk_en && uf[2] |=> timer_underflow_flag[2] && timer_underflow[2])
		else $error("timer2 underflow did not set its flag");

	chk_cascade_step: assert property ( // [R8] [R15]
		s_t1_cascade_tick |=> cnt_q[1] == $past(cnt_q[1]) - 16'h0001)
		else $error("timer1 did not count a timer0 underflow");

	chk_reload_hold: assert property ( // [R11] [R16]
		clk_en && wr_access && !start_ev[0] && !tick[0] && !uf[0] |=> cnt_q[0] == $past(cnt_q[0]))
		else $error("timer0 count changed by a register write");

	chk_freeze: assert property (
		!clk_en |=> cnt_q[2] == $past(cnt_q[2]) && run_q == $past(run_q))
		else $error("state changed while the clock enable was low");

endmodule // rgt_timers

`default_nettype wire

// *** tb_top.sv ***
// Self-checking testbench for the three general timers.
`include "rgt_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import rgt_pkg::*;

	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	rgt_apb_req_t apb_req = '0;
	rgt_apb_rsp_t apb_rsp;
	logic carrier_clk_pin = 1'b0;
	logic divided_clk_pin = 1'b0;
	logic low_freq_oscillator = 1'b0;
	logic tx_end = 1'b0;
	logic rx_first_nibble = 1'b0;
	logic [2:0] timer_running;
	logic [2:0] timer_underflow_flag;
	logic [2:0] timer_underflow;
	int miscompares = 0;
	int samples_checked = 0;

	rgt_timers uut (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.apb_req(apb_req),
		.apb_rsp(apb_rsp),
		.carrier_clk_pin(carrier_clk_pin),
		.divided_clk_pin(divided_clk_pin),
		.low_freq_oscillator(low_freq_oscillator),
		.tx_end(tx_end),
		.rx_first_nibble(rx_first_nibble),
		.timer_running(timer_running),
		.timer_underflow_flag(timer_underflow_flag),
		.timer_underflow(timer_underflow)
	);

	always #20 sys_clk = ~sys_clk;

	// ****************************************************************
	// Bus cycles and comparisons.
	// ****************************************************************
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	task automatic bus(input logic [5:0] idx, input logic wr, input logic [7:0] wd,
			output logic [7:0] rdv, output logic err);
		int n;
		n = 0;
		@(posedge sys_clk);
		apb_req <= '{1'b1, 1'b0, wr, {idx, 2'b00}, {24'h0, wd}};
		@(posedge sys_clk);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (apb_rsp.pready !== 1'b1 && n < 20);
		rdv = apb_rsp.prdata[7:0];
		err = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
		chk("pready", 16'h1, {15'h0, apb_rsp.pready});
	endtask

	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		logic [7:0] r;
		logic e;
		bus(idx, 1'b1, d, r, e);
	endtask

	task automatic rd_chk(input string nm, input logic [5:0] idx, input logic [7:0] exp);
		logic [7:0] r;
		logic e;
		bus(idx, 1'b0, 8'h00, r, e);
		chk(nm, {8'h00, exp}, {8'h00, r});
	endtask

	task automatic cnt_chk(input string nm, input int t, input logic [15:0] exp);
		logic [5:0] base;
		logic [7:0] hi;
		logic [7:0] lo;
		logic e;
		base = 6'(`RGT_IDX_T0_CNT_HI + t * `RGT_IDX_STRIDE);
		bus(base, 1'b0, 8'h00, hi, e);
		bus(base + 6'h01, 1'b0, 8'h00, lo, e);
		chk(nm, exp, {hi, lo});
	endtask

	// The running bits settle at the edge that ends the access, so look one edge later.
	task automatic run_chk(input logic [2:0] exp);
		@(posedge sys_clk);
		chk("running", {13'h0, exp}, {13'h0, timer_running});
	endtask

	// Each tick is a pin pulse long enough to survive the two-flop synchroniser.
	task automatic tick(input logic sel, input int n);
		repeat (n) begin
			carrier_clk_pin <= ~sel;
			divided_clk_pin <= sel;
			idle(2);
			carrier_clk_pin <= 1'b0;
			divided_clk_pin <= 1'b0;
			idle(2);
		end
		idle(6);
	endtask

	task automatic pulse(input logic rx);
		tx_end <= ~rx;
		rx_first_nibble <= rx;
		@(posedge sys_clk);
		tx_end <= 1'b0;
		rx_first_nibble <= 1'b0;
		idle(3);
	endtask

	task automatic osc_rise();
		low_freq_oscillator <= 1'b0;
		idle(4);
		low_freq_oscillator <= 1'b1;
		idle(6);
	endtask

	// ****************************************************************
	// Scenarios.
	// ****************************************************************
	task automatic regs_access();
		logic [7:0] r;
		logic e;
		rd_chk("t0_ctl_reset", `RGT_IDX_T0_CTL, 8'h00);
		wr(`RGT_IDX_T0_CTL, 8'hff);
		rd_chk("t0_ctl_rsvd", `RGT_IDX_T0_CTL, 8'hbb);
		wr(`RGT_IDX_T0_CTL, 8'h00);
		wr(`RGT_IDX_T1_RLD_HI, 8'ha5);
		rd_chk("t1_rld_hi", `RGT_IDX_T1_RLD_HI, 8'ha5);
		wr(`RGT_IDX_T1_RLD_HI, 8'h00);
		wr(`RGT_IDX_T0_CNT_LO, 8'hff);
		cnt_chk("t0_cnt_ro", 0, 16'h0000);
		bus(6'h3f, 1'b0, 8'h00, r, e);
		chk("unmapped_err", 16'h1, {15'h0, e});
	endtask

	task automatic run_mask();
		logic [7:0] r;
		logic e;
		wr(`RGT_IDX_T0_RLD_LO, 8'h05);
		wr(`RGT_IDX_SHARED_CTL, 8'hf0);
		run_chk(3'b000);
		wr(`RGT_IDX_SHARED_CTL, 8'h11);
		run_chk(3'b001);
		bus(`RGT_IDX_SHARED_CTL, 1'b0, 8'h00, r, e);
		chk("shared_run0", 16'h10, {8'h00, r & 8'h10});
		cnt_chk("t0_loaded", 0, 16'h0005);
		wr(`RGT_IDX_T0_RLD_LO, 8'h09);
		cnt_chk("t0_no_reload", 0, 16'h0005);
		wr(`RGT_IDX_SHARED_CTL, 8'h01);
		run_chk(3'b000);
	endtask

	task automatic count_cascade();
		wr(`RGT_IDX_T0_RLD_LO, 8'h02);
		wr(`RGT_IDX_T0_CTL, 8'h08);
		wr(`RGT_IDX_T2_RLD_LO, 8'h05);
		wr(`RGT_IDX_T2_CTL, 8'h02);
		wr(`RGT_IDX_SHARED_CTL, 8'h55);
		tick(1'b0, 6);
		cnt_chk("t0_auto", 0, 16'h0002);
		cnt_chk("t2_cascade", 2, 16'h0003);
		run_chk(3'b101);
		wr(`RGT_IDX_T1_RLD_LO, 8'h03);
		wr(`RGT_IDX_T1_CTL, 8'h01);
		wr(`RGT_IDX_SHARED_CTL, 8'h22);
		tick(1'b1, 3);
		cnt_chk("t1_divided", 1, 16'h0000);
		run_chk(3'b111);
		tick(1'b1, 1);
		run_chk(3'b101);
		chk("uf_flags", 16'h3, {13'h0, timer_underflow_flag});
		rd_chk("flags_reg", `RGT_IDX_FLAGS, 8'h03);
		wr(`RGT_IDX_FLAGS, 8'h07);
		rd_chk("flags_clr", `RGT_IDX_FLAGS, 8'h00);
		wr(`RGT_IDX_SHARED_CTL, 8'h07);
		run_chk(3'b000);
	endtask

	task automatic events();
		wr(`RGT_IDX_T1_CTL, 8'h91);
		wr(`RGT_IDX_T0_CTL, 8'h80);
		wr(`RGT_IDX_T2_CTL, 8'h00);
		wr(`RGT_IDX_SHARED_CTL, 8'h11);
		pulse(1'b0);
		run_chk(3'b011);
		cnt_chk("t1_tx_start", 1, 16'h0003);
		// Counters are read only after the receive pulse is over.
		pulse(1'b1);
		run_chk(3'b000);
		wr(`RGT_IDX_T2_CTL, 8'ha0);
		osc_rise();
		run_chk(3'b100);
		pulse(1'b1);
		run_chk(3'b100);
		osc_rise();
		run_chk(3'b000);
		wr(`RGT_IDX_T2_CTL, 8'hb0);
		osc_rise();
		run_chk(3'b100);
		clk_en <= 1'b0;
		tick(1'b0, 2);
		clk_en <= 1'b1;
		idle(2);
		cnt_chk("t2_frozen", 2, 16'h0005);
		run_chk(3'b100);
	endtask

	task automatic tally_and_finish();
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		idle(10);
		rst_n <= 1'b1;
		regs_access();
		run_mask();
		count_cascade();
		events();
		tally_and_finish();
	end

	initial begin
		idle(8000);
		miscompares++;
		tally_and_finish();
	end

endmodule // tb_top

`default_nettype wire
